// ### design/dac_pattern_waveform_generator.sv
// Behaviour
// - dac code changes on rising or falling clock edge per edge-invert bit.
// - run bit arms the generator; clearing it shuts the generator down.
// - armed trigger fall enters pattern-on after programmed pattern delay.
// - trigger rise requests end of pattern generation.
// - read-only pattern bit shows 1 when on, 0 when off.
// - continuous mode outputs the waveform from start offset to end of on state, ignoring periods.
// - pulse-train mode outputs waveform once per period, periods back to back.
// - period length is period register times unit size clocks.
// - waveform starts a start offset, in start-base units, into each period.
// - samples multiplied by 12-bit signed gain, range plus or minus two.
// - 12-bit signed dc offset added to dac samples.
// - source register picks saw, noise, dc, dds sine, sram or modulated sine.
// - repeat kind bit picks endless trains or a counted number of periods.
// - pulsed sine limited to programmed cycles; phase shift applied to dds.
// - marker drives shared pin only in three-wire mode with drive bit set.
// - marker mode 0 makes the pin follow the manual level bit.
// - marker mode 1: rise after 16-bit delay, fall 4-bit delay after stop.
// - dds uses 24-bit tuning word, f = word times clock over 2^24.
// - tuning word from fixed fields or sram value plus high field bits.
// - 4096 x 14 sram mapped at 0x6000 to 0x6FFF.
// - while running, address counter steps start to stop after start delay.
// - while running, sram served only outside start-to-stop address range.
// - address counter steps each clock, or on dds top bit rising.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = count != FULL;
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
    AST_FIFO_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
        count == FULL && !pop |=> count == FULL && !in_ready)
        else $error("fifo count left full without a pop");
endmodule

module dac_pattern_waveform_generator #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic trigger_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dac_pattern_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dac_pattern_pkg::DATA_W-1:0] reg_wdata,
    output logic [dac_pattern_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic dac_ready,
    output logic [dac_pattern_pkg::CODE_W-1:0] dac_code,
    output logic marker_pin_o,
    output logic marker_pin_oe
);
    import dac_pattern_pkg::*;

    logic [15:0] regs [0:127];
    logic [13:0] sram [0:SRAM_WORDS-1];
    gen_state_t st;
    gen_state_t next_st;
    logic [15:0] dly_cnt;
    logic t1, t2, t3;
    logic [3:0] unit_cnt, sd_unit;
    logic [15:0] per_cnt, sd_cnt, rpt_cnt, cyc_cnt, mk_cnt;
    logic [11:0] addr_cnt;
    logic wave_done, msb_q, mk_wait, mk_on, mk_fall;
    logic [23:0] acc;
    logic [13:0] saw, lfsr, sram_q, raw, pos_code, neg_code;
    logic fifo_in_ready, fifo_out_valid;
    logic [13:0] fifo_out_data;

    wire [15:0] spi_r = regs[A_SPI[6:0]];
    wire [15:0] clk_r = regs[A_CLK[6:0]];
    wire [15:0] status_r = regs[A_STATUS[6:0]];
    wire [15:0] type_r = regs[A_TYPE[6:0]];
    wire [15:0] pdly_r = regs[A_PDLY[6:0]];
    wire [15:0] dof_r = regs[A_DOF[6:0]];
    wire [15:0] wav_r = regs[A_WAV[6:0]];
    wire [15:0] tbase_r = regs[A_TBASE[6:0]];
    wire [15:0] period_r = regs[A_PERIOD[6:0]];
    wire [15:0] rpt_r = regs[A_RPT[6:0]];
    wire [15:0] mk_rise_r = regs[A_MK_RISE[6:0]];
    wire [15:0] mk_set_r = regs[A_MK_SET[6:0]];
    wire [15:0] gain_r = regs[A_GAIN[6:0]];
    wire [15:0] cyc_r = regs[A_CYC[6:0]];
    wire [15:0] tw_hi_r = regs[A_TW_HI[6:0]];
    wire [15:0] tw_lo_r = regs[A_TW_LO[6:0]];
    wire [15:0] phase_r = regs[A_PHASE[6:0]];
    wire [15:0] dds_cfg_r = regs[A_DDS_CFG[6:0]];
    wire [15:0] start_ofs_r = regs[A_START_OFS[6:0]];
    wire [11:0] start_addr = regs[A_START_ADDR[6:0]][11:0];
    wire [11:0] stop_addr = regs[A_STOP_ADDR[6:0]][11:0];

    wire run = status_r[B_RUN];
    wire mem_access = status_r[B_MEM];
    wire buf_read = status_r[B_BUF_READ];
    wire repeat_kind = type_r[B_RPT_KIND];
    wire cont = type_r[B_CONT];
    wire output_edge_invert = clk_r[B_EDGE_INV];
    wire three_wire = spi_r[B_THREE_WIRE] || spi_r[B_THREE_WIRE_M];
    wire pin_drive = spi_r[B_DRIVE] || spi_r[B_DRIVE_M];
    wire mk_mode = mk_set_r[B_MK_MODE];
    wire marker_manual_level = mk_set_r[B_MK_MAN];
    wire counter_step_by_sine_top = dds_cfg_r[B_STEP_TOP];
    wire [2:0] src = wav_r[2:0];

    // register and sram access port
    wire reg_hit = reg_addr[15:7] == 9'h000 && REG_MAP[reg_addr[6:0]];
    wire is_sram = reg_addr[15:12] == SRAM_PAGE;
    wire [11:0] host_addr = reg_addr[11:0];
    wire in_range = host_addr >= start_addr && host_addr <= stop_addr;
    wire host_ok = run ? !in_range : mem_access;
    wire sram_wr_ok = reg_wr && is_sram && host_ok && (run || !buf_read);
    wire sram_rd_ok = reg_rd && is_sram && host_ok && (run || buf_read);
    wire [15:0] status_view = (status_r & ~PATTERN_MASK)
        | ((st == ST_ON) ? PATTERN_MASK : 16'h0000);
    wire [15:0] next_rdata = sram_rd_ok ? {2'b00, sram[host_addr]}
        : !reg_hit ? 16'h0000
        : (reg_addr == A_STATUS) ? status_view : regs[reg_addr[6:0]];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) begin
                regs[i] <= '0;
            end
            regs[A_GAIN[6:0]] <= RST_GAIN;
        end else if (reg_wr && reg_hit) begin
            regs[reg_addr[6:0]] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= reg_rd ? next_rdata : 16'h0000;
        end
    end

    // trigger synchroniser and edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {t1, t2, t3} <= 3'b111;
        end else begin
            {t1, t2, t3} <= {trigger_n, t1, t2};
        end
    end
    wire trig_fall = t3 && !t2;
    wire trig_rise = !t3 && t2;

    // pattern state machine
    wire on = st == ST_ON;
    wire adv = fifo_in_ready;
    wire unit_tick = unit_cnt == tbase_r[7:4];
    wire per_end = unit_tick && per_cnt == period_r - 16'h0001;
    wire sd_tick = sd_unit == tbase_r[3:0];
    wire sd_done = sd_cnt == start_ofs_r;
    wire new_per = on && adv && per_end && !cont;
    wire fin_stop = new_per && repeat_kind && rpt_cnt == rpt_r - 16'h0001;
    wire start_evt = st == ST_OFF && run && trig_fall;
    wire stop_evt = on && (trig_rise || !run || fin_stop);
    wire gen_stop = st != ST_OFF && next_st == ST_OFF;

    always_comb begin
        next_st = st;
        unique case (st)
            ST_OFF: begin
                if (start_evt) next_st = ST_DELAY;
            end
            ST_DELAY: begin
                if (!run || trig_rise) next_st = ST_OFF;
                else if (dly_cnt == 16'h0000) next_st = ST_ON;
            end
            ST_ON: begin
                if (stop_evt) next_st = ST_OFF;
            end
            default: next_st = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= ST_OFF;
            dly_cnt <= '0;
        end else begin
            st <= next_st;
            if (start_evt) dly_cnt <= pdly_r;
            else if (st == ST_DELAY && dly_cnt != 16'h0000) dly_cnt <= dly_cnt - 16'h0001;
        end
    end

    // period, start delay and repeat counters
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !on) begin
            {unit_cnt, sd_unit} <= '0;
            {per_cnt, sd_cnt, rpt_cnt} <= '0;
        end else if (adv) begin
            unit_cnt <= unit_tick ? 4'h0 : unit_cnt + 4'h1;
            per_cnt <= new_per ? 16'h0000 : per_cnt + 16'(unit_tick);
            if (new_per) begin
                {sd_unit, sd_cnt} <= '0;
                rpt_cnt <= rpt_cnt + 16'h0001;
            end else if (!sd_done) begin
                sd_unit <= sd_tick ? 4'h0 : sd_unit + 4'h1;
                sd_cnt <= sd_cnt + 16'(sd_tick);
            end
        end
    end

    // sram address counter and sine cycle limit
    wire msb_rise = acc[23] && !msb_q;
    wire step = adv && (counter_step_by_sine_top ? msb_rise : 1'b1);
    wire wave_act = on && sd_done && !wave_done;
    wire at_stop = addr_cnt == stop_addr;
    wire cyc_hit = cyc_r != 16'h0000 && cyc_cnt == cyc_r;
    wire dds_src = src == SRC_DDS || src == SRC_AM;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !on || new_per) begin
            addr_cnt <= start_addr;
            wave_done <= 1'b0;
            cyc_cnt <= '0;
        end else if (wave_act) begin
            if (step) addr_cnt <= at_stop ? start_addr : addr_cnt + 12'h001;
            if (adv && msb_rise) cyc_cnt <= cyc_cnt + 16'h0001;
            if (!cont && (dds_src ? cyc_hit : step && at_stop)) wave_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sram_wr_ok) sram[host_addr] <= reg_wdata[13:0];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) sram_q <= '0;
        else if (adv) sram_q <= sram[addr_cnt];
    end

    // dds, sawtooth and noise sources
    wire [23:0] tw_fixed = {tw_hi_r, tw_lo_r[15:8]};
    wire [23:0] tw_ram = {tw_hi_r[15:6], sram_q};
    wire [23:0] tuning_word = dds_cfg_r[B_TW_RAM] ? tw_ram : tw_fixed;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc <= '0;
            msb_q <= 1'b0;
            saw <= '0;
            lfsr <= 14'h0001;
        end else if (adv) begin
            acc <= acc + tuning_word;
            msb_q <= acc[23];
            saw <= saw + 14'h0001;
            lfsr <= {lfsr[12:0], lfsr[13] ^ lfsr[12] ^ lfsr[11] ^ lfsr[1]};
        end
    end

    // parabolic sine from the phase-shifted accumulator top
    wire [9:0] phase = 10'(acc[23:14] + phase_r[15:6]);
    wire [8:0] px = phase[8:0];
    wire [18:0] para = px * (10'h200 - {1'b0, px});
    wire signed [13:0] mag = $signed({1'b0, para[16:4]});
    wire signed [13:0] sine = phase[9] ? -mag : mag;
    wire signed [27:0] am = sine * $signed(sram_q);

    always_comb begin
        raw = 14'h0000;
        case (src)
            SRC_RAM: raw = sram_q;
            SRC_SAW: raw = saw;
            SRC_NOISE: raw = lfsr;
            SRC_DDS: raw = sine;
            SRC_AM: raw = am[26:13];
            default: raw = 14'h0000;
        endcase
    end

    function automatic logic [13:0] sat14(input logic signed [17:0] v);
        if (v > 18'sd8191) return 14'h1FFF;
        if (v < -18'sd8192) return 14'h2000;
        return v[13:0];
    endfunction

    // gain, offset and conversion to offset binary
    wire signed [13:0] samp = wave_act ? $signed(raw) : 14'sd0;
    wire signed [25:0] gprod = samp * $signed(gain_r[11:0]);
    wire signed [15:0] gscaled = gprod[25:GAIN_FRAC];
    wire [13:0] gsat = sat14({{2{gscaled[15]}}, gscaled});
    wire signed [17:0] osum = $signed({{4{gsat[13]}}, gsat})
        + $signed({{4{dof_r[11]}}, dof_r[11:0], 2'b00});
    wire [13:0] osat = sat14(osum);
    wire [13:0] fifo_in = {~osat[13], osat[12:0]};

    sample_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(1'b1),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(dac_ready),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) pos_code <= '0;
        else if (fifo_out_valid && dac_ready) pos_code <= fifo_out_data;
    end

    always_ff @(negedge clk_sys) begin
        if (!rst_n) neg_code <= '0;
        else neg_code <= pos_code;
    end

    assign dac_code = output_edge_invert ? neg_code : pos_code;

    // marker output
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {mk_wait, mk_on, mk_fall} <= 3'b000;
            mk_cnt <= '0;
            marker_pin_o <= 1'b0;
            marker_pin_oe <= 1'b0;
        end else begin
            marker_pin_o <= mk_mode ? mk_on : marker_manual_level;
            marker_pin_oe <= three_wire && pin_drive;
            if (start_evt) begin
                // a fall still pending from the last pattern is applied now
                mk_wait <= 1'b1;
                mk_fall <= 1'b0;
                mk_on <= 1'b0;
                mk_cnt <= mk_rise_r;
            end else if (gen_stop) begin
                mk_wait <= 1'b0;
                mk_fall <= 1'b1;
                mk_cnt <= {12'h000, mk_set_r[3:0]};
            end else if (mk_cnt != 16'h0000) begin
                mk_cnt <= mk_cnt - 16'h0001;
            end else if (mk_wait) begin
                mk_wait <= 1'b0;
                mk_on <= 1'b1;
            end else if (mk_fall) begin
                mk_fall <= 1'b0;
                mk_on <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_EDGE_SEL: assert property (!output_edge_invert |-> dac_code == pos_code)
        else $error("rising edge selected but dac code not from rising flop");
    AST_RUN_OFF: assert property (!run ##1 !run |-> st == ST_OFF)
        else $error("generator not off while run is clear");
    AST_TRIG_START: assert property (start_evt |=> st == ST_DELAY
        && dly_cnt == $past(pdly_r))
        else $error("armed trigger fall did not load pattern delay");
    AST_TRIG_STOP: assert property (on && trig_rise |=> st == ST_OFF)
        else $error("trigger rise did not end pattern");
    AST_STATUS_BIT: assert property (reg_rd && reg_addr == A_STATUS |=>
        reg_rvalid && reg_rdata[B_PATTERN] == $past(on))
        else $error("pattern status bit does not match state");
    AST_FIN_REPEAT: assert property (fin_stop |=> st == ST_OFF)
        else $error("finite repeat count did not stop generator");
    AST_PIN_DRIVE: assert property (!(three_wire && pin_drive) |=> !marker_pin_oe)
        else $error("marker pin driven outside three-wire drive mode");
    AST_MANUAL: assert property (!mk_mode |=>
        marker_pin_o == $past(marker_manual_level))
        else $error("manual marker level not followed");
    AST_SYNC: assert property (trig_fall |->
        $past(trigger_n, 3) && !$past(trigger_n, 2))
        else $error("trigger fall seen without synchronised edge");
    AST_DELAY_END: assert property (st == ST_DELAY && dly_cnt == 16'h0000
        && run && !trig_rise |=> on)
        else $error("pattern delay expired without entering on state");
endmodule

// ### design/dac_pattern_pkg.sv
package dac_pattern_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int CODE_W = 14;
    localparam int SRAM_AW = 12;
    localparam int SRAM_WORDS = 4096;
    localparam int GAIN_FRAC = 10;
    // register offsets
    localparam logic [15:0] A_SPI = 16'h0000;
    localparam logic [15:0] A_CLK = 16'h0002;
    localparam logic [15:0] A_STATUS = 16'h001E;
    localparam logic [15:0] A_TYPE = 16'h001F;
    localparam logic [15:0] A_PDLY = 16'h0020;
    localparam logic [15:0] A_DOF = 16'h0025;
    localparam logic [15:0] A_WAV = 16'h0027;
    localparam logic [15:0] A_TBASE = 16'h0028;
    localparam logic [15:0] A_PERIOD = 16'h0029;
    localparam logic [15:0] A_RPT = 16'h002B;
    localparam logic [15:0] A_MK_RISE = 16'h002C;
    localparam logic [15:0] A_MK_SET = 16'h002D;
    localparam logic [15:0] A_GAIN = 16'h0035;
    localparam logic [15:0] A_CYC = 16'h003B;
    localparam logic [15:0] A_TW_HI = 16'h003E;
    localparam logic [15:0] A_TW_LO = 16'h003F;
    localparam logic [15:0] A_PHASE = 16'h0043;
    localparam logic [15:0] A_DDS_CFG = 16'h0045;
    localparam logic [15:0] A_START_OFS = 16'h005C;
    localparam logic [15:0] A_START_ADDR = 16'h005D;
    localparam logic [15:0] A_STOP_ADDR = 16'h005E;
    localparam logic [3:0] SRAM_PAGE = 4'h6;
    localparam logic [127:0] REG_MAP = (128'h1 << A_SPI) | (128'h1 << A_CLK)
        | (128'h1 << A_STATUS) | (128'h1 << A_TYPE) | (128'h1 << A_PDLY)
        | (128'h1 << A_DOF) | (128'h1 << A_WAV) | (128'h1 << A_TBASE)
        | (128'h1 << A_PERIOD) | (128'h1 << A_RPT) | (128'h1 << A_MK_RISE)
        | (128'h1 << A_MK_SET) | (128'h1 << A_GAIN) | (128'h1 << A_CYC)
        | (128'h1 << A_TW_HI) | (128'h1 << A_TW_LO) | (128'h1 << A_PHASE)
        | (128'h1 << A_DDS_CFG) | (128'h1 << A_START_OFS)
        | (128'h1 << A_START_ADDR) | (128'h1 << A_STOP_ADDR);
    // field positions
    localparam int B_THREE_WIRE = 14;
    localparam int B_DRIVE = 11;
    localparam int B_DRIVE_M = 4;
    localparam int B_THREE_WIRE_M = 1;
    localparam int B_EDGE_INV = 3;
    localparam int B_RUN = 0;
    localparam int B_PATTERN = 1;
    localparam int B_MEM = 2;
    localparam int B_BUF_READ = 3;
    localparam int B_RPT_KIND = 0;
    localparam int B_CONT = 1;
    localparam int B_MK_MODE = 8;
    localparam int B_MK_MAN = 7;
    localparam int B_TW_RAM = 1;
    localparam int B_STEP_TOP = 2;
    localparam logic [15:0] PATTERN_MASK = 16'h0002;
    localparam logic [15:0] RST_GAIN = 16'h0400;
    // waveform sources; any other code selects the dc constant (zero)
    localparam logic [2:0] SRC_RAM = 3'h0;
    localparam logic [2:0] SRC_SAW = 3'h1;
    localparam logic [2:0] SRC_NOISE = 3'h2;
    localparam logic [2:0] SRC_DDS = 3'h4;
    localparam logic [2:0] SRC_AM = 3'h5;
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_DELAY = 3'b010,
        ST_ON = 3'b100
    } gen_state_t;
endpackage

// ### sim/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic stall,
    output logic trigger_n,
    output logic dac_ready
);
    initial begin
        trigger_n = 1'b1;
        dac_ready = 1'b0;
    end
    // pin held low while a pattern is wanted, its rise asks for the end
    always @(posedge clk_sys) begin
        trigger_n <= #1 ~fire;
        dac_ready <= #1 ~stall;
    end
endmodule

// ### sim/test_dac_pattern_waveform_generator.sv
`timescale 1ns/1ps
module test_dac_pattern_waveform_generator;
    import dac_pattern_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 16'h0000;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic fire = 1'b0;
    logic stall = 1'b1;
    logic trigger_n;
    logic dac_ready;
    logic [CODE_W-1:0] dac_code;
    logic marker_pin_o;
    logic marker_pin_oe;
    logic [DATA_W-1:0] rd;
    int mismatches = 0;
    int checks = 0;
    logic [15:0] ra [10] = '{A_CLK, A_TYPE, A_DOF, A_WAV, A_TBASE, A_RPT, A_MK_RISE,
        A_MK_SET, A_GAIN, A_START_OFS};
    logic [15:0] rv [10] = '{16'h0008, 16'h0001, 16'h0123, 16'h0004, 16'h0011,
        16'h0002, 16'hbeef, 16'h0085, 16'h0800, 16'h0007};

    always #4 clk_sys = ~clk_sys;

    dac_pattern_waveform_generator #(.FIFO_DEPTH(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .trigger_n(trigger_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .dac_ready(dac_ready), .dac_code(dac_code), .marker_pin_o(marker_pin_o),
        .marker_pin_oe(marker_pin_oe));
    far_side_model partner_u (.clk_sys(clk_sys), .fire(fire), .stall(stall),
        .trigger_n(trigger_n), .dac_ready(dac_ready));

    task automatic print_verdict();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask

    // answer stands in the cycle right after the read edge
    task automatic rd_reg(input logic [15:0] a);
        reg_rd = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd = 1'b0;
        compare({15'h0000, reg_rvalid}, 16'h0001);
        rd = reg_rdata;
        step(1);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        rd_reg(a);
        compare(rd, exp);
    endtask

    task automatic wait_st(input logic [15:0] exp);
        for (int k = 0; k < 40; k++) begin
            rd_reg(A_STATUS);
            if ((rd & PATTERN_MASK) === exp) begin
                compare(rd & PATTERN_MASK, exp);
                return;
            end
        end
        compare(rd & PATTERN_MASK, exp);
        print_verdict();
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        rd_chk(A_GAIN, RST_GAIN);
        rd_chk(A_DOF, 16'h0000);
        rd_chk(16'h0001, 16'h0000);
        compare({15'h0000, marker_pin_oe}, 16'h0000);
        for (int k = 0; k < 10; k++) begin
            wr(ra[k], rv[k]);
            rd_chk(ra[k], rv[k]);
            wr(ra[k], (ra[k] == A_GAIN) ? RST_GAIN : 16'h0000);
        end
        wr(A_STATUS, PATTERN_MASK);
        rd_chk(A_STATUS, 16'h0000);
        // sram: write path, read path, then refusals
        wr(A_STATUS, 16'h0004);
        wr(16'h6005, 16'h1234);
        wr(16'h6fff, 16'h3fff);
        wr(A_STATUS, 16'h000c);
        rd_chk(16'h6005, 16'h1234);
        rd_chk(16'h6fff, 16'h3fff);
        wr(16'h6005, 16'h0001);
        rd_chk(16'h6005, 16'h1234);
        wr(A_STATUS, 16'h0000);
        rd_chk(16'h6005, 16'h0000);
        wr(A_START_ADDR, 16'h0010);
        wr(A_STOP_ADDR, 16'h0020);
        wr(A_STATUS, 16'h0001);
        wr(16'h6005, 16'h0abc);
        rd_chk(16'h6005, 16'h0abc);
        rd_chk(16'h6015, 16'h0000);
        wr(A_STATUS, 16'h0000);
        // marker pin in manual mode
        wr(A_SPI, 16'h4800);
        wr(A_MK_SET, 16'h0080);
        step(2);
        compare({14'h0000, marker_pin_oe, marker_pin_o}, 16'h0003);
        wr(A_MK_SET, 16'h0000);
        wr(A_SPI, 16'h4000);
        step(2);
        compare({14'h0000, marker_pin_oe, marker_pin_o}, 16'h0000);
        wr(A_SPI, 16'h0012);
        step(2);
        compare({15'h0000, marker_pin_oe}, 16'h0001);
        // trigger while disarmed does nothing
        fire = 1'b1;
        step(12);
        rd_chk(A_STATUS, 16'h0000);
        fire = 1'b0;
        step(6);
        // continuous dc pattern with offset and timed marker
        wr(A_PDLY, 16'h0004);
        wr(A_TYPE, 16'h0002);
        wr(A_WAV, 16'h0003);
        wr(A_DOF, 16'h0010);
        wr(A_MK_RISE, 16'h0003);
        wr(A_MK_SET, 16'h0102);
        wr(A_STATUS, 16'h0001);
        fire = 1'b1;
        wait_st(PATTERN_MASK);
        step(10);
        compare({15'h0000, marker_pin_o}, 16'h0001);
        stall = 1'b0;
        step(12);
        compare({2'b00, dac_code}, 16'h2040);
        fire = 1'b0;
        wait_st(16'h0000);
        step(8);
        compare({15'h0000, marker_pin_o}, 16'h0000);
        fire = 1'b1;
        wait_st(PATTERN_MASK);
        wr(A_STATUS, 16'h0000);
        wait_st(16'h0000);
        fire = 1'b0;
        step(6);
        // counted pulse train ends by itself and the marker falls
        wr(A_TYPE, 16'h0001);
        wr(A_RPT, 16'h0002);
        wr(A_PERIOD, 16'h0008);
        wr(A_PDLY, 16'h0000);
        wr(A_STATUS, 16'h0001);
        stall = 1'b1;
        fire = 1'b1;
        wait_st(PATTERN_MASK);
        stall = 1'b0;
        wait_st(16'h0000);
        fire = 1'b0;
        step(4);
        compare({15'h0000, marker_pin_o}, 16'h0000);
        // continuous sram word at half gain, output on the falling edge
        wr(A_STATUS, 16'h0004);
        wr(16'h6010, 16'h0100);
        wr(A_STOP_ADDR, 16'h0010);
        wr(A_TYPE, 16'h0002);
        wr(A_WAV, 16'h0000);
        wr(A_GAIN, 16'h0200);
        wr(A_CLK, 16'h0008);
        wr(A_STATUS, 16'h0001);
        fire = 1'b1;
        wait_st(PATTERN_MASK);
        step(12);
        compare({2'b00, dac_code}, 16'h20c0);
        fire = 1'b0;
        wait_st(16'h0000);
        print_verdict();
    end
endmodule
